// ---- core/eifs_params.svh ----
`ifndef EIFS_PARAMS_SVH
`define EIFS_PARAMS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define EIFS_ADDR_FILTER_SEL 4'h0
`define EIFS_ADDR_DISABLE_SEL 4'h4
`define EIFS_ADDR_STATUS 4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EIFS_SYNC_BIT 0
`define EIFS_QUAL_BIT 1
`define EIFS_CH_STRIDE 8
`define EIFS_DIS_GPIO_BIT 0
`define EIFS_DIS_ERR_BIT 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EIFS_FILTER_SEL_RST 32'h01010101
`define EIFS_DISABLE_SEL_RST 32'h00000001

// ----------------------------------------
// Qualifier span
// ----------------------------------------
`define EIFS_QUAL_BITS 6
`define EIFS_QUAL_MAX 6'h3F

`endif

// ---- core/eifs_pkg.sv ----
package eifs_pkg;
  typedef enum {
    EIFS_SYNC_ONLY,
    EIFS_QUALIFIED
  } eifs_mode_e;
  typedef logic [31:0] eifs_word_t;
endpackage

// ---- core/eifs_top.sv ----
`timescale 1ns/100ps
`include "eifs_params.svh"
module eifs_top
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // Avalon-MM slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [1:0] AVS_RESPONSE,
  // Privilege of the current access
  input wire logic AVS_PRIVILEGED,
  // Encoder pins and sources
  input wire logic QUAD_INPUT_A,
  input wire logic QUAD_INPUT_B,
  input wire logic QUAD_INDEX_INPUT,
  input wire logic QUAD_STROBE_INPUT,
  input wire logic QUAD_ERROR_FLAG,
  input wire logic GPIO_A_BIT5,
  // Conditioned outputs
  output logic [3:0] QUAD_COND_OUT,
  output logic TIMER_PIN_DISABLE_IN
);

  // ----------------------------------------
  // Registers and bus
  // ----------------------------------------
  // Control registers
  eifs_pkg::eifs_word_t filter_sel_ff;
  eifs_pkg::eifs_word_t disable_sel_ff;
  logic ack_ff;

  // Pin conditioning state
  logic [3:0] raw_in;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] qual_ff;
  logic [3:0] cond_ff;
  logic err_sync1_ff;
  logic err_sync2_ff;
  logic [3:0] mode_qual;
  logic err_src_sel;

  // Bus decode
  logic bus_req;
  logic wr_ok;
  logic addr_hit;
  logic wr_filter;
  logic wr_disable;
  logic resp_err;
  eifs_pkg::eifs_word_t status_word;
  eifs_pkg::eifs_word_t rd_mux;

  assign raw_in = {QUAD_STROBE_INPUT, QUAD_INDEX_INPUT, QUAD_INPUT_B, QUAD_INPUT_A};

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // A request is taken once; ack_ff blocks a second take while it is answered
  assign bus_req = (AVS_READ | AVS_WRITE) & ~ack_ff;
  assign addr_hit = (AVS_ADDRESS == `EIFS_ADDR_FILTER_SEL) ||
                    (AVS_ADDRESS == `EIFS_ADDR_DISABLE_SEL) ||
                    (AVS_ADDRESS == `EIFS_ADDR_STATUS);
  // Write lands on the edge where the master sees waitrequest low
  // Non-privileged writes are dropped and answered with an error
  assign wr_ok = AVS_WRITE & ack_ff & AVS_PRIVILEGED;
  assign wr_filter = wr_ok & (AVS_ADDRESS == `EIFS_ADDR_FILTER_SEL);
  assign wr_disable = wr_ok & (AVS_ADDRESS == `EIFS_ADDR_DISABLE_SEL);
  // Status is read-only: a write there is accepted and ignored
  assign resp_err = ~addr_hit | (AVS_WRITE & ~AVS_PRIVILEGED);
  // Lets software see live conditioned levels and modes
  assign status_word = {23'h000000, TIMER_PIN_DISABLE_IN, mode_qual, cond_ff};

  // Unmapped addresses read as zero
  always_comb
  begin
    unique case (AVS_ADDRESS)
      `EIFS_ADDR_FILTER_SEL: rd_mux = filter_sel_ff;
      `EIFS_ADDR_DISABLE_SEL: rd_mux = disable_sel_ff;
      `EIFS_ADDR_STATUS: rd_mux = status_word;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait cycle, then an answer on the next edge
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      ack_ff <= 1'b0;
    else
      ack_ff <= bus_req;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= ~bus_req;
  end

  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  // Error code is valid only while waitrequest is low
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      AVS_RESPONSE <= 2'h0;
    else if (bus_req)
      AVS_RESPONSE <= resp_err ? 2'h2 : 2'h0;
    else
      AVS_RESPONSE <= 2'h0;
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Byte enables pick lanes; other lanes keep their value
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      filter_sel_ff <= `EIFS_FILTER_SEL_RST;
    else if (wr_filter)
    begin
      for (int i = 0; i < 4; i++)
        if (AVS_BYTEENABLE[i])
          filter_sel_ff[i*8 +: 8] <= AVS_WRITEDATA[i*8 +: 8];
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      disable_sel_ff <= `EIFS_DISABLE_SEL_RST;
    else if (wr_disable)
    begin
      for (int i = 0; i < 4; i++)
        if (AVS_BYTEENABLE[i])
          disable_sel_ff[i*8 +: 8] <= AVS_WRITEDATA[i*8 +: 8];
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      AVS_READDATA <= 32'h00000000;
    // Captured at the taking edge, so it stands while waitrequest is low
    else if (AVS_READ && !ack_ff)
      AVS_READDATA <= rd_mux;
  end

  // ----------------------------------------
  // Per-channel conditioning
  // ----------------------------------------
  // Only the exact pattern sync=0,qual=1 qualifies; the illegal 0/0 falls back to sync-only
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_chan
      logic [`EIFS_QUAL_BITS-1:0] cnt_ff;
      eifs_pkg::eifs_mode_e mode;
      logic lvl_held;
      logic span_done;

      // ----------------------------------------
      // Mode decode
      // ----------------------------------------
      // Each channel decodes its own byte of the filter register
      assign mode_qual[ch] = ~filter_sel_ff[ch*`EIFS_CH_STRIDE + `EIFS_SYNC_BIT] &
                             filter_sel_ff[ch*`EIFS_CH_STRIDE + `EIFS_QUAL_BIT];
      assign mode = mode_qual[ch] ? eifs_pkg::EIFS_QUALIFIED
                                  : eifs_pkg::EIFS_SYNC_ONLY;

      // ----------------------------------------
      // Synchronizer
      // ----------------------------------------
      // Two-stage synchronizer, first stage read only by the second
      always_ff @(posedge CLK_SYS)
      begin
        if (SYS_RST)
        begin
          sync1_ff[ch] <= 1'b0;
          sync2_ff[ch] <= 1'b0;
        end
        else
        begin
          sync1_ff[ch] <= raw_in[ch];
          sync2_ff[ch] <= sync1_ff[ch];
        end
      end

      // ----------------------------------------
      // Qualifier
      // ----------------------------------------
      // Six bits give a 64-cycle span; a shorter pulse never reaches the output
      assign lvl_held = (sync2_ff[ch] == qual_ff[ch]);
      assign span_done = (cnt_ff == `EIFS_QUAL_MAX);

      // Qualifier restarts whenever the synced level matches its held output
      always_ff @(posedge CLK_SYS)
      begin
        if (SYS_RST)
        begin
          cnt_ff <= '0;
          qual_ff[ch] <= 1'b0;
        end
        else if (lvl_held)
          cnt_ff <= '0;
        else if (span_done)
        begin
          qual_ff[ch] <= sync2_ff[ch];
          cnt_ff <= '0;
        end
        else
          cnt_ff <= cnt_ff + 1'b1;
      end

      // ----------------------------------------
      // Output select
      // ----------------------------------------
      // Entering qualified mode shows the qualifier's held level at once
      always_ff @(posedge CLK_SYS)
      begin
        if (SYS_RST)
          cond_ff[ch] <= 1'b0;
        else
        begin
          unique case (mode)
            eifs_pkg::EIFS_QUALIFIED: cond_ff[ch] <= qual_ff[ch];
            eifs_pkg::EIFS_SYNC_ONLY: cond_ff[ch] <= sync2_ff[ch];
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Conditioned outputs
  // ----------------------------------------
  assign QUAD_COND_OUT = cond_ff;

  // ----------------------------------------
  // Timer disable source
  // ----------------------------------------
  // Reset to the inverted idle flag, so no false disable follows reset
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      err_sync1_ff <= 1'b1;
      err_sync2_ff <= 1'b1;
    end
    else
    begin
      err_sync1_ff <= ~QUAD_ERROR_FLAG;
      err_sync2_ff <= err_sync1_ff;
    end
  end

  // ----------------------------------------
  // Disable output select
  // ----------------------------------------
  // Only the exact pattern gpio=0,err=1 picks the error flag; 0/0 falls back to GPIO
  assign err_src_sel = ~disable_sel_ff[`EIFS_DIS_GPIO_BIT] &
                       disable_sel_ff[`EIFS_DIS_ERR_BIT];

  // Output flop adds one cycle even to the direct GPIO path, needed for a registered output
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      TIMER_PIN_DISABLE_IN <= 1'b1;
    else if (err_src_sel)
      TIMER_PIN_DISABLE_IN <= err_sync2_ff;
    else
      TIMER_PIN_DISABLE_IN <= GPIO_A_BIT5;
  end

endmodule

// ---- verif/eifs_enc_model.sv ----
`timescale 1ns/100ps
module eifs_enc_model
(
  // Clock and command
  input wire logic clk,
  input wire logic [4:0] lvl,
  // Pins: error, strobe, index, B, A
  output logic [4:0] pins
);
  // Sensor edges land just after a clock edge
  always_ff @(posedge clk)
  begin
    pins <= lvl;
  end
endmodule

// ---- verif/eifs_top_props.sv ----
`timescale 1ns/100ps
module eifs_top_props
(
  // Bus
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_PRIVILEGED,
  input wire logic AVS_WAITREQUEST,
  input wire logic [1:0] AVS_RESPONSE,
  // Pins
  input wire logic QUAD_INPUT_A,
  input wire logic QUAD_INPUT_B,
  input wire logic QUAD_INDEX_INPUT,
  input wire logic QUAD_STROBE_INPUT,
  input wire logic QUAD_ERROR_FLAG,
  input wire logic GPIO_A_BIT5,
  input wire logic [3:0] QUAD_COND_OUT,
  input wire logic TIMER_PIN_DISABLE_IN
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence s_req;
    $rose(AVS_READ || AVS_WRITE);
  endsequence
  a_bus_answer: assert property (s_req |-> ##[1:2] !AVS_WAITREQUEST)
    else $error("request not answered");
  a_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  a_priv_err: assert property (!AVS_WAITREQUEST && AVS_WRITE && !AVS_PRIVILEGED
    |-> AVS_RESPONSE == 2'h2) else $error("unprivileged write not refused");
  a_reset_outs: assert property (disable iff (1'b0) SYS_RST |=> AVS_WAITREQUEST
    && QUAD_COND_OUT == 4'h0 && TIMER_PIN_DISABLE_IN) else $error("bad reset state");
  a_chan_a: assert property ($changed(QUAD_COND_OUT[0])
    |-> QUAD_COND_OUT[0] == $past(QUAD_INPUT_A, 3)) else $error("A output bad");
  a_chan_b: assert property ($changed(QUAD_COND_OUT[1])
    |-> QUAD_COND_OUT[1] == $past(QUAD_INPUT_B, 3)) else $error("B output bad");
  a_chan_index: assert property ($changed(QUAD_COND_OUT[2])
    |-> QUAD_COND_OUT[2] == $past(QUAD_INDEX_INPUT, 3)) else $error("index output bad");
  a_chan_strobe: assert property ($changed(QUAD_COND_OUT[3])
    |-> QUAD_COND_OUT[3] == $past(QUAD_STROBE_INPUT, 3)) else $error("strobe output bad");
  a_disable_src: assert property ($changed(TIMER_PIN_DISABLE_IN)
    |-> TIMER_PIN_DISABLE_IN == $past(GPIO_A_BIT5)
    || TIMER_PIN_DISABLE_IN == !$past(QUAD_ERROR_FLAG, 3)) else $error("disable bad");
endmodule
bind eifs_top eifs_top_props u_props (.CLK_SYS, .SYS_RST, .AVS_READ, .AVS_WRITE,
  .AVS_PRIVILEGED, .AVS_WAITREQUEST, .AVS_RESPONSE, .QUAD_INPUT_A, .QUAD_INPUT_B,
  .QUAD_INDEX_INPUT, .QUAD_STROBE_INPUT, .QUAD_ERROR_FLAG, .GPIO_A_BIT5,
  .QUAD_COND_OUT, .TIMER_PIN_DISABLE_IN);

// ---- verif/tb_encoder_input_filter_select.sv ----
`timescale 1ns/100ps
module tb_encoder_input_filter_select;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic priv = 1'b1;
  logic gpio = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [4:0] lvl = 5'h0;
  logic [31:0] rdata, got;
  logic [1:0] resp, got_resp;
  logic wait_req, dis;
  logic [4:0] pins;
  logic [3:0] cond;
  int err_count = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  eifs_enc_model enc (.clk(clk), .lvl(lvl), .pins(pins));
  eifs_top dut (.CLK_SYS(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .AVS_RESPONSE(resp), .AVS_PRIVILEGED(priv),
    .QUAD_INPUT_A(pins[0]), .QUAD_INPUT_B(pins[1]), .QUAD_INDEX_INPUT(pins[2]),
    .QUAD_STROBE_INPUT(pins[3]), .QUAD_ERROR_FLAG(pins[4]), .GPIO_A_BIT5(gpio),
    .QUAD_COND_OUT(cond), .TIMER_PIN_DISABLE_IN(dis));
  task automatic stop_test();
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    compares++;
    if (act !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, act, exp);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic p);
    int n;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    priv <= p;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (wait_req !== 1'b0)
    begin
      err_count++;
      stop_test();
    end
    else
    begin
      got = rdata;
      got_resp = resp;
      rd <= 1'b0;
      wr <= 1'b0;
      // Idle edge keeps the next call from reassigning in this time step
      @(posedge clk);
    end
  endtask
  task automatic step(input int n, input logic [4:0] v);
    lvl <= v;
    repeat (n) @(posedge clk);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    acc(1'b0, 4'h0, 32'h0, 1'b1);
    check(got, 32'h01010101);
    acc(1'b0, 4'h4, 32'h0, 1'b1);
    check(got, 32'h00000001);
    acc(1'b0, 4'hC, 32'h0, 1'b1);
    check(got_resp, 2'h2);
    acc(1'b1, 4'h0, 32'h02020202, 1'b0);
    check(got_resp, 2'h2);
    acc(1'b0, 4'h0, 32'h0, 1'b1);
    check(got, 32'h01010101);
    step(5, 5'h0F);
    check(cond, 4'hF);
    step(5, 5'h00);
    check(cond, 4'h0);
    acc(1'b1, 4'h0, 32'h02020202, 1'b1);
    check(got_resp, 2'h0);
    step(60, 5'h0F);
    check(cond, 4'h0);
    step(15, 5'h0F);
    check(cond, 4'hF);
    step(30, 5'h00);
    check(cond, 4'hF);
    step(5, 5'h0F);
    step(60, 5'h00);
    check(cond, 4'hF);
    step(15, 5'h00);
    check(cond, 4'h0);
    acc(1'b1, 4'h0, 32'h0, 1'b1);
    step(5, 5'h0F);
    check(cond, 4'hF);
    step(5, 5'h00);
    acc(1'b1, 4'h0, 32'h01020102, 1'b1);
    step(5, 5'h0F);
    check(cond, 4'hA);
    acc(1'b0, 4'h8, 32'h0, 1'b1);
    check(got, 32'h0000005A);
    step(75, 5'h00);
    gpio <= 1'b1;
    step(3, 5'h00);
    check(dis, 1'b1);
    acc(1'b1, 4'h4, 32'h2, 1'b1);
    gpio <= 1'b0;
    step(5, 5'h00);
    check(dis, 1'b1);
    step(5, 5'h10);
    check(dis, 1'b0);
    gpio <= 1'b1;
    acc(1'b1, 4'h4, 32'h0, 1'b1);
    step(3, 5'h10);
    check(dis, 1'b1);
    stop_test();
  end
endmodule
